// ===== pio_ports.sv
// Purpose: eight-port parallel i/o bank with data latches and direction registers on apb
// Assumes: pad inputs synchronous to pclk; converter select held by its owner
// Notes: pads are level, drive enable and input; the ring resolves the wire
//
// Operation
// - a direction bit of one turns on its pin driver, zero leaves the pin an input.
// - reset clears the direction bits of all eight ports.
// - reset leaves the data latches untouched.
// - with the direction bit at one a data read returns the latch bit.
// - with the direction bit at zero a data read returns the pin level.
// - a data write always loads the latch whatever the direction.
// - a converter-selected pin reads zero as input and the latch as output.
// - a pin in converter use ignores its direction bit for driving but not for reading.
// - the converter channel select decides which shared pins are analogue.
// - port c has six pins; data bits 7 and 6 and direction bit 6 read zero.
// - the clock-output enable in port c direction bit 7 sends the clock out on c2.
// - sixteen byte registers are decoded, data and direction per port group.
// - unimplemented bits of ports f, g and h read as zero.
// - with clock output on, direction bit c2 has no effect; reset clears the enable.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ns

module pio_ports (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [4:0] converter_channel_select,
    input wire logic [7:0][7:0] pad_in,
    output logic [7:0][7:0] pad_out,
    output logic [7:0][7:0] pad_oe
);

    // ==========================================================
    // bus decode
    pio_pkg::pio_apb_req_t req;
    assign req = '{paddr: paddr, pwrite: pwrite, pwdata: pwdata, pstrb: pstrb};

    logic pready_q;
    logic [31:0] prdata_q;
    logic pslverr_q;

    wire access = psel & penable;
    wire first_access = access & ~pready_q;
    wire [3:0] reg_idx = req.paddr[5:2];
    // anything outside the sixteen aligned words is refused
    wire mapped = (req.paddr[31:6] == 26'h0000000) & (req.paddr[1:0] == 2'h0);
    wire is_dir = reg_idx[pio_pkg::PIO_IDX_DIR_BIT];
    wire [2:0] port_sel = {reg_idx[pio_pkg::PIO_IDX_HI_BIT], reg_idx[1:0]};
    // write lands only at the completing edge
    wire wr_ok = access & pready_q & req.pwrite & mapped & req.pstrb[0];

    // ==========================================================
    // storage
    logic [7:0][7:0] latch_q;
    logic [7:0][7:0] dir_q;
    logic clk_div_q;
    logic [7:0][7:0] pad_out_q;
    logic [7:0][7:0] pad_oe_q;

    wire clock_out_enable = dir_q[pio_pkg::PIO_PORT_C][pio_pkg::PIO_CLK_EN_BIT];

    genvar gp;
    generate
        for (gp = 0; gp < pio_pkg::PIO_PORTS; gp++) begin : g_port
            wire hit = wr_ok & (port_sel == 3'(gp));
            // no reset on purpose: latches keep their contents through reset
            always_ff @(posedge pclk) begin
                if (hit & ~is_dir) begin
                    latch_q[gp] <= req.pwdata[7:0];
                end
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    dir_q[gp] <= pio_pkg::PIO_DIR_RESET;
                end else if (hit & is_dir) begin
                    dir_q[gp] <= req.pwdata[7:0] & pio_pkg::PIO_DIR_MASK[gp];
                end
            end
        end
    endgenerate

    // ==========================================================
    // converter ownership
    logic [7:0][7:0] conv_pin;
    always_comb begin
        conv_pin = '0;
        for (int b = 0; b < pio_pkg::PIO_WIDTH; b++) begin
            conv_pin[pio_pkg::PIO_PORT_B][b] =
                (converter_channel_select == pio_pkg::PIO_CONV_B_FIRST + 5'(b));
        end
        for (int b = 0; b < pio_pkg::PIO_CONV_D_PINS; b++) begin
            conv_pin[pio_pkg::PIO_PORT_D][b] =
                (converter_channel_select == pio_pkg::PIO_CONV_D_FIRST + 5'(b));
        end
    end

    // ==========================================================
    // pad drive
    logic [7:0][7:0] oe_d;
    logic [7:0][7:0] out_d;
    always_comb begin
        for (int p = 0; p < pio_pkg::PIO_PORTS; p++) begin
            // a pin taken by the converter is never driven
            oe_d[p] = dir_q[p] & ~conv_pin[p] & pio_pkg::PIO_DATA_MASK[p];
            out_d[p] = latch_q[p] & pio_pkg::PIO_DATA_MASK[p];
        end
        if (clock_out_enable) begin
            oe_d[pio_pkg::PIO_PORT_C][pio_pkg::PIO_CLK_PIN_BIT] = 1'b1;
            out_d[pio_pkg::PIO_PORT_C][pio_pkg::PIO_CLK_PIN_BIT] = clk_div_q;
        end
    end

    // ==========================================================
    // read path
    logic [7:0][7:0] data_rd;
    always_comb begin
        for (int p = 0; p < pio_pkg::PIO_PORTS; p++) begin
            // converter pins read zero as inputs rather than the analogue level
            data_rd[p] = (dir_q[p] & latch_q[p])
                       | (~dir_q[p] & ~conv_pin[p] & pad_in[p]);
            data_rd[p] = data_rd[p] & pio_pkg::PIO_DATA_MASK[p];
        end
        if (clock_out_enable) begin
            data_rd[pio_pkg::PIO_PORT_C][pio_pkg::PIO_CLK_PIN_BIT] = 1'b0;
        end
    end

    wire [7:0] rd_byte = is_dir ? dir_q[port_sel] : data_rd[port_sel];
    wire [31:0] rd_word = mapped ? {24'h000000, rd_byte} : 32'h00000000;

    // ==========================================================
    // flops facing the ports
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else begin
            // one wait state: sample in the first access cycle, finish in the next
            pready_q <= first_access;
            pslverr_q <= first_access & ~mapped;
            if (first_access) begin
                prdata_q <= req.pwrite ? 32'h00000000 : rd_word;
            end
        end
    end

    // pads follow one pclk edge late because every output leaves a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_div_q <= 1'b0;
            pad_out_q <= '0;
            pad_oe_q <= '0;
        end else begin
            clk_div_q <= clock_out_enable & ~clk_div_q;
            pad_out_q <= out_d;
            pad_oe_q <= oe_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign pad_out = pad_out_q;
    assign pad_oe = pad_oe_q;

endmodule

// ===== pio_pkg.sv
// Purpose: constants and carrier types for the parallel i/o port bank
// Assumes: apb register access, one aligned 32-bit word per byte register
// Notes: port index 0..7 stands for ports a..h
package pio_pkg;

    // ==========================================================
    // register map (index; byte address is four times the index)
    localparam logic [3:0] PIO_IDX_PORT_A_DATA = 4'h0;
    localparam logic [3:0] PIO_IDX_PORT_B_DATA = 4'h1;
    localparam logic [3:0] PIO_IDX_PORT_C_DATA = 4'h2;
    localparam logic [3:0] PIO_IDX_PORT_D_DATA = 4'h3;
    localparam logic [3:0] PIO_IDX_PORT_A_DIRECTION = 4'h4;
    localparam logic [3:0] PIO_IDX_PORT_B_DIRECTION = 4'h5;
    localparam logic [3:0] PIO_IDX_PORT_C_DIRECTION = 4'h6;
    localparam logic [3:0] PIO_IDX_PORT_D_DIRECTION = 4'h7;
    localparam logic [3:0] PIO_IDX_PORT_E_DATA = 4'h8;
    localparam logic [3:0] PIO_IDX_PORT_F_DATA = 4'h9;
    localparam logic [3:0] PIO_IDX_PORT_G_DATA = 4'ha;
    localparam logic [3:0] PIO_IDX_PORT_H_DATA = 4'hb;
    localparam logic [3:0] PIO_IDX_PORT_E_DIRECTION = 4'hc;
    localparam logic [3:0] PIO_IDX_PORT_F_DIRECTION = 4'hd;
    localparam logic [3:0] PIO_IDX_PORT_G_DIRECTION = 4'he;
    localparam logic [3:0] PIO_IDX_PORT_H_DIRECTION = 4'hf;
    // index bit that marks a direction register
    localparam int PIO_IDX_DIR_BIT = 2;
    // index bit that selects the upper group of ports e..h
    localparam int PIO_IDX_HI_BIT = 3;

    localparam int PIO_PORTS = 8;
    localparam int PIO_WIDTH = 8;
    localparam int PIO_PORT_B = 1;
    localparam int PIO_PORT_C = 2;
    localparam int PIO_PORT_D = 3;

    // implemented bits, ports h down to a
    localparam logic [7:0][7:0] PIO_DATA_MASK =
        {8'h03, 8'h07, 8'h7f, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff};
    localparam logic [7:0][7:0] PIO_DIR_MASK =
        {8'h03, 8'h07, 8'h7f, 8'hff, 8'hff, 8'hbf, 8'hff, 8'hff};
    localparam logic [7:0] PIO_DIR_RESET = 8'h00;

    // clock output control on port c
    localparam int PIO_CLK_EN_BIT = 7;
    localparam int PIO_CLK_PIN_BIT = 2;

    // converter channels: 0..7 on port b, 8..14 on port d bits 0..6
    localparam logic [4:0] PIO_CONV_B_FIRST = 5'h00;
    localparam logic [4:0] PIO_CONV_D_FIRST = 5'h08;
    localparam int PIO_CONV_D_PINS = 7;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic [31:0] paddr;
        logic pwrite;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } pio_apb_req_t;

    typedef struct packed {
        logic [7:0][7:0] level;
        logic [7:0][7:0] drive_en;
    } pio_pad_t;

endpackage

// ===== pio_checker.sv
// Purpose: port assertions for the parallel i/o bank
// Assumes: apb slave with one wait state
// Notes: bound into pio_ports
`timescale 1ns/1ns
module pio_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [4:0] converter_channel_select,
    input wire logic [7:0][7:0] pad_oe
);
    // ==========
    // properties
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic bad_a;
    logic [4:0] cs;
    assign bad_a = paddr[31:6] != 26'h0 || paddr[1:0] != 2'h0;
    assign cs = converter_channel_select;
    wait_state_a: assert property (psel && penable && !pready |=> pready)
        else $error("apb answer late");
    setup_quiet_a: assert property (psel && !penable |-> !pready)
        else $error("ready in setup");
    bad_addr_a: assert property (psel && pready && bad_a |-> pslverr)
        else $error("no error on bad address");
    good_addr_a: assert property (psel && pready && !bad_a |-> !pslverr && prdata[31:8] == 24'h0)
        else $error("bad answer on mapped address");
    reset_dir_a: assert property ($rose(presetn) |-> pad_oe == 64'h0)
        else $error("driver on after reset");
    no_pin_a: assert property (pad_oe[2][7:6] == 2'h0 && !pad_oe[5][7] && pad_oe[6][7:3] == 5'h0
        && pad_oe[7][7:2] == 6'h0)
        else $error("missing pin driven");
    conv_b_a: assert property (cs < 5'h08 && $stable(cs) |-> !pad_oe[1][cs[2:0]])
        else $error("converter pin b driven");
    conv_d_a: assert property (cs inside {[5'h08:5'h0e]} && $stable(cs) |-> !pad_oe[3][cs[2:0]])
        else $error("converter pin d driven");
endmodule
bind pio_ports pio_checker pio_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .converter_channel_select(converter_channel_select), .pad_oe(pad_oe));

// ===== pio_pad_ring.sv
// Purpose: board side of the pins
// Assumes: one board level per pin
// Notes: an enabled driver wins over the board
`timescale 1ns/1ns
module pio_pad_ring (
    input wire logic [7:0][7:0] pad_out,
    input wire logic [7:0][7:0] pad_oe,
    input wire logic [7:0][7:0] ext_level,
    output logic [7:0][7:0] pad_in
);
    assign pad_in = (pad_out & pad_oe) | (ext_level & ~pad_oe);
endmodule

// ===== parallel_io_ports_tb.sv
// Purpose: register and pin tests of the parallel i/o bank
// Assumes: one wait state, pins settle one edge after a write
// Notes: byte strobe tied to lane 0
`timescale 1ns/1ns
module parallel_io_ports_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [31:0] paddr = 0, pwdata = 0, prdata;
    logic [3:0] pstrb = 4'h1;
    logic [4:0] csel = 5'h1f;
    logic [7:0][7:0] ext = '0, pad_in, pad_out, pad_oe;
    logic [32:0] r;
    int mismatches = 0, n_compared = 0, cyc = 0, i;
    pio_ports pio_ports_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .converter_channel_select(csel),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe));
    pio_pad_ring pio_pad_ring_i (.pad_out(pad_out), .pad_oe(pad_oe), .ext_level(ext),
        .pad_in(pad_in));
    initial forever #2 pclk = ~pclk;
    // ==========
    // tasks
    task automatic stop_test();
        $display("mismatches %0d n_compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // hang guard, far above the few hundred cycles needed
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            stop_test();
        end
    end
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = {pslverr, prdata};
        psel <= 0;
        penable <= 0;
    endtask
    function automatic logic [31:0] ra(input int p, input logic dir);
        return {26'h0, p[2], dir, p[1:0], 2'h0};
    endfunction
    // ==========
    // sequence
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        for (i = 0; i < 8; i++) begin
            apb(0, ra(i, 1), 0);
            chk(r, 33'h0);
            apb(1, ra(i, 0), 8'hff);
            ext[i] <= 8'ha5;
            apb(0, ra(i, 0), 0);
            chk(r, {25'h0, 8'ha5 & pio_pkg::PIO_DATA_MASK[i]});
            apb(1, ra(i, 1), 8'hff);
            apb(0, ra(i, 1), 0);
            chk(r, {25'h0, pio_pkg::PIO_DIR_MASK[i]});
            apb(0, ra(i, 0), 0);
            chk(r, {25'h0, pio_pkg::PIO_DATA_MASK[i] & (i == 2 ? 8'hfb : 8'hff)});
            chk({25'h0, pad_oe[i]}, {25'h0, pio_pkg::PIO_DATA_MASK[i]});
        end
        chk({25'h0, pad_out[0]}, 33'hff);
        r[0] = pad_out[2][2];
        @(posedge pclk);
        chk({32'h0, pad_out[2][2]}, {32'h0, ~r[0]});
        apb(1, 32'h18, 8'h80);
        repeat (2) @(posedge pclk);
        chk({25'h0, pad_oe[2]}, 33'h04);
        csel <= 5'h03;
        ext[1] <= 8'hff;
        apb(0, 32'h04, 0);
        chk(r, 33'hff);
        chk({25'h0, pad_oe[1]}, 33'hf7);
        apb(1, 32'h14, 8'h00);
        apb(0, 32'h04, 0);
        chk(r, 33'hf7);
        csel <= 5'h0a;
        repeat (2) @(posedge pclk);
        chk({25'h0, pad_oe[3]}, 33'hfb);
        apb(0, 32'h40, 0);
        chk(r, 33'h100000000);
        apb(1, 32'h02, 0);
        chk({32'h0, r[32]}, 33'h1);
        presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        apb(0, 32'h18, 0);
        chk(r, 33'h0);
        apb(1, 32'h10, 8'hff);
        apb(0, 32'h00, 0);
        chk(r, 33'hff);
        stop_test();
    end
endmodule
